//--- csg_pkg.sv
package csg_pkg;

    ////////////////////////////////////////////////////////////////////////
    // register byte offsets (haddr[7:0])
    localparam logic [7:0] OFF_TRIGGER = 8'h00;
    localparam logic [7:0] OFF_EXPNUM = 8'h04;
    localparam logic [7:0] OFF_RDNUM = 8'h08;
    localparam logic [7:0] OFF_CTRL = 8'h0c;
    localparam logic [7:0] OFF_STATUS = 8'h10;
    // per-gate block: 8'h40 + 8'h10 * gate, then field, on, off words
    localparam logic [1:0] GATE_REGION = 2'h1;
    localparam logic [1:0] GSEL_FIELD = 2'h0;
    localparam logic [1:0] GSEL_ON_POS = 2'h1;
    localparam logic [1:0] GSEL_OFF_POS = 2'h2;

    ////////////////////////////////////////////////////////////////////////
    // trigger register bits
    localparam int TRIG_ALL_GATES = 0;
    localparam int TRIG_BIAS_LSB = 4;
    localparam int TRIG_EXPOSE = 6;
    localparam int TRIG_READOUT = 7;

    // control register fields
    localparam int CTRL_POL_LSB = 0;
    localparam int CTRL_MAN_EN_LSB = 4;
    localparam int CTRL_MAN_ON_LSB = 8;
    localparam int CTRL_BPOL_LSB = 12;
    localparam int CTRL_BMODE_LSB = 14;
    localparam int CTRL_KEEP_LSB = 16;
    localparam int CTRL_W = 18;

    // gate word fields: field/pixel in low half, off field/line in high half
    localparam int LO_LSB = 0;
    localparam int HI_LSB = 16;

    // status register fields
    localparam int STAT_GATE_LSB = 0;
    localparam int STAT_BIAS_LSB = 4;
    localparam int STAT_SEQ_LSB = 6;
    localparam int STAT_RDF_LSB = 8;
    localparam int STAT_EXPF_LSB = 16;

    ////////////////////////////////////////////////////////////////////////
    // widths and reset values
    localparam int CW = 12;
    localparam int RW = 3;
    localparam logic [CTRL_W-1:0] CTRL_RESET = 18'h0300f;
    localparam logic [CW-1:0] EXPNUM_RESET = 12'h000;
    localparam logic [RW-1:0] RDNUM_RESET = 3'h0;
    localparam logic [31:0] GATE_WORD_RESET = 32'h0000_0000;

    typedef enum logic [1:0] {SEQ_IDLE, SEQ_EXPOSE, SEQ_READOUT} csg_seq_t;

endpackage

//--- csg_shutter_gen.sv
// Notes on behaviour
// - auto mode starts enabled gates with the exposure trigger; readout alone gives single.
// - on and off edges placed by field, line and pixel settings.
// - in auto mode, line/pixel settings apply only when field matches exposure counter.
// - edges placeable from exposure field 0 to the last exposure field.
// - on and off edges have independent field settings.
// - gate triggered without exposure bit runs in single trigger mode.
// - single trigger: both edges in next field, field settings ignored.
// - gate plus exposure requested together while the sequencer is idle runs in automatic mode.
// - manual mode uses on or off position chosen by manual state bit.
// - manual mode makes at most one toggle per field.
// - manual mode ignores on and off field settings.
// - manual enable per gate, independent of exposure triggering.
// - gate turned on manually stays on when manual is disabled.
// - trigger on an already-on gate skips on-edge, does off-edge only.
// - each bias output active level follows its polarity setting.
// - bias mode 0 active at exposure start, mode 1 at readout start.
// - bias goes inactive at end of readout unless hold is set.
// - hold option keeps bias active after readout finishes.
// - gate drives its polarity level while on, opposite otherwise.
// - trigger bit 6 requests exposure; others gates, bias, readout.
module csg_shutter_gen (
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp,
    // video timing, one-cycle pulses
    input wire logic field_sync,
    input wire logic line_sync,
    // shutter and bias outputs
    output logic [3:0] mech_gate,
    output logic substrate_bias_a,
    output logic substrate_bias_b
);

    ////////////////////////////////////////////////////////////////////////
    // bus front end: zero wait states, read data loaded in address phase
    logic wr_pend_reg;
    logic [7:0] wr_addr_reg;
    logic hreadyout_reg;
    logic [31:0] hrdata_reg;
    logic [31:0] rd_value;

    wire addr_phase = hsel & htrans[1] & hready;
    wire wr_en = wr_pend_reg;
    wire [7:0] rd_addr = haddr[7:0];
    wire wr_gate_region = wr_addr_reg[7:6] == csg_pkg::GATE_REGION;
    wire [1:0] wr_gate = wr_addr_reg[5:4];
    wire [1:0] wr_gsel = wr_addr_reg[3:2];
    wire wr_trig = wr_en & (wr_addr_reg == csg_pkg::OFF_TRIGGER);
    wire wr_expnum = wr_en & (wr_addr_reg == csg_pkg::OFF_EXPNUM);
    wire wr_rdnum = wr_en & (wr_addr_reg == csg_pkg::OFF_RDNUM);
    wire wr_ctrl = wr_en & (wr_addr_reg == csg_pkg::OFF_CTRL);

    always_ff @(posedge clk) begin
        if (reset) begin
            wr_pend_reg <= 1'b0;
            wr_addr_reg <= 8'h00;
            hreadyout_reg <= 1'b1;
            hrdata_reg <= 32'h0000_0000;
        end else begin
            wr_pend_reg <= addr_phase & hwrite;
            wr_addr_reg <= haddr[7:0];
            hreadyout_reg <= 1'b1;
            if (addr_phase & ~hwrite) begin
                hrdata_reg <= rd_value;
            end
        end
    end

    assign hreadyout = hreadyout_reg;
    assign hrdata = hrdata_reg;
    assign hresp = 1'b0;

    ////////////////////////////////////////////////////////////////////////
    // configuration registers
    logic [7:0] trig_pend_reg;
    logic [csg_pkg::CW-1:0] expnum_reg;
    logic [csg_pkg::RW-1:0] rdnum_reg;
    logic [csg_pkg::CTRL_W-1:0] ctrl_reg;
    logic [31:0] field_word_reg [4];
    logic [31:0] on_word_reg [4];
    logic [31:0] off_word_reg [4];

    wire [3:0] gate_pol = ctrl_reg[csg_pkg::CTRL_POL_LSB +: 4];
    wire [3:0] man_en = ctrl_reg[csg_pkg::CTRL_MAN_EN_LSB +: 4];
    wire [3:0] man_on = ctrl_reg[csg_pkg::CTRL_MAN_ON_LSB +: 4];
    wire [1:0] bias_polarity = ctrl_reg[csg_pkg::CTRL_BPOL_LSB +: 2];
    wire [1:0] bias_mode = ctrl_reg[csg_pkg::CTRL_BMODE_LSB +: 2];
    wire [1:0] bias_hold_after_readout =
        ctrl_reg[csg_pkg::CTRL_KEEP_LSB +: 2];

    // a request written in the same cycle as field_sync waits for the next
    // field, so a consume never swallows a fresh write
    wire [7:0] trig_next = (field_sync ? 8'h00 : trig_pend_reg)
        | (wr_trig ? hwdata[7:0] : 8'h00);

    always_ff @(posedge clk) begin
        if (reset) begin
            trig_pend_reg <= 8'h00;
            expnum_reg <= csg_pkg::EXPNUM_RESET;
            rdnum_reg <= csg_pkg::RDNUM_RESET;
            ctrl_reg <= csg_pkg::CTRL_RESET;
        end else begin
            trig_pend_reg <= trig_next;
            if (wr_expnum) begin
                expnum_reg <= hwdata[csg_pkg::CW-1:0];
            end
            if (wr_rdnum) begin
                rdnum_reg <= hwdata[csg_pkg::RW-1:0];
            end
            if (wr_ctrl) begin
                ctrl_reg <= hwdata[csg_pkg::CTRL_W-1:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // line and pixel position counters
    logic [csg_pkg::CW-1:0] pix_cnt_reg;
    logic [csg_pkg::CW-1:0] line_cnt_reg;

    always_ff @(posedge clk) begin
        if (reset) begin
            pix_cnt_reg <= '0;
            line_cnt_reg <= '0;
        end else begin
            pix_cnt_reg <= (field_sync | line_sync) ? '0 : pix_cnt_reg + 1'b1;
            if (field_sync) begin
                line_cnt_reg <= '0;
            end else if (line_sync) begin
                line_cnt_reg <= line_cnt_reg + 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // exposure / readout sequencer, advances once per field
    csg_pkg::csg_seq_t seq_reg;
    logic [csg_pkg::CW-1:0] exp_field_reg;
    logic [csg_pkg::RW-1:0] rd_field_reg;

    wire pend_exp = trig_pend_reg[csg_pkg::TRIG_EXPOSE];
    wire pend_rd = trig_pend_reg[csg_pkg::TRIG_READOUT];
    wire seq_idle = seq_reg == csg_pkg::SEQ_IDLE;
    wire seq_expose = seq_reg == csg_pkg::SEQ_EXPOSE;
    wire seq_readout = seq_reg == csg_pkg::SEQ_READOUT;
    wire go_expose = field_sync & seq_idle & pend_exp;
    wire go_readout_only = field_sync & seq_idle & ~pend_exp & pend_rd;
    wire exp_last = exp_field_reg == expnum_reg;
    wire rd_last = rd_field_reg == rdnum_reg;

    always_ff @(posedge clk) begin
        if (reset) begin
            seq_reg <= csg_pkg::SEQ_IDLE;
            exp_field_reg <= '0;
            rd_field_reg <= '0;
        end else if (field_sync) begin
            case (seq_reg)
                csg_pkg::SEQ_IDLE: begin
                    exp_field_reg <= '0;
                    rd_field_reg <= '0;
                    if (pend_exp) begin
                        seq_reg <= csg_pkg::SEQ_EXPOSE;
                    end else if (pend_rd) begin
                        seq_reg <= csg_pkg::SEQ_READOUT;
                    end
                end
                csg_pkg::SEQ_EXPOSE: begin
                    // readout follows the exposure on its own
                    if (exp_last) begin
                        seq_reg <= csg_pkg::SEQ_READOUT;
                    end else begin
                        exp_field_reg <= exp_field_reg + 1'b1;
                    end
                end
                csg_pkg::SEQ_READOUT: begin
                    if (rd_last) begin
                        seq_reg <= csg_pkg::SEQ_IDLE;
                    end else begin
                        rd_field_reg <= rd_field_reg + 1'b1;
                    end
                end
                default: begin
                    seq_reg <= csg_pkg::SEQ_IDLE;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // per-gate shutter logic
    logic [3:0] gate_on_reg;
    logic [3:0] gate_out_reg;

    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : gate
            logic auto_reg;
            logic single_reg;
            logic toggled_reg;
            wire [csg_pkg::CW-1:0] on_fd =
                field_word_reg[g][csg_pkg::LO_LSB +: csg_pkg::CW];
            wire [csg_pkg::CW-1:0] off_fd =
                field_word_reg[g][csg_pkg::HI_LSB +: csg_pkg::CW];
            wire [csg_pkg::CW-1:0] on_px =
                on_word_reg[g][csg_pkg::LO_LSB +: csg_pkg::CW];
            wire [csg_pkg::CW-1:0] on_ln =
                on_word_reg[g][csg_pkg::HI_LSB +: csg_pkg::CW];
            wire [csg_pkg::CW-1:0] off_px =
                off_word_reg[g][csg_pkg::LO_LSB +: csg_pkg::CW];
            wire [csg_pkg::CW-1:0] off_ln =
                off_word_reg[g][csg_pkg::HI_LSB +: csg_pkg::CW];
            wire req = trig_pend_reg[g] | trig_pend_reg[csg_pkg::TRIG_ALL_GATES];
            wire take = field_sync & req;
            // exposure bit decides auto versus single
            wire take_auto = take & go_expose;
            wire take_single = take & ~pend_exp;
            wire wr_here = wr_en & wr_gate_region & (wr_gate == 2'(g));
            // field qualification; manual and single ignore field settings
            wire on_fld = man_en[g] ? (man_on[g] & ~toggled_reg)
                : single_reg ? 1'b1
                : auto_reg & seq_expose & (exp_field_reg == on_fd);
            wire off_fld = man_en[g] ? (~man_on[g] & ~toggled_reg)
                : single_reg ? 1'b1
                : auto_reg & seq_expose & (exp_field_reg == off_fd);
            wire on_pos = (line_cnt_reg == on_ln) & (pix_cnt_reg == on_px);
            wire off_pos = (line_cnt_reg == off_ln) & (pix_cnt_reg == off_px);
            // an already-on gate skips its on-edge
            wire on_hit = on_fld & on_pos & ~gate_on_reg[g];
            wire off_raw = off_fld & off_pos;
            wire off_hit = off_raw & gate_on_reg[g];
            wire on_next = on_hit | (gate_on_reg[g] & ~off_hit);
            // auto arming lasts through the exposure fields only
            wire auto_end = (~man_en[g] & off_raw)
                | (field_sync & seq_expose & exp_last);

            always_ff @(posedge clk) begin
                if (reset) begin
                    field_word_reg[g] <= csg_pkg::GATE_WORD_RESET;
                    on_word_reg[g] <= csg_pkg::GATE_WORD_RESET;
                    off_word_reg[g] <= csg_pkg::GATE_WORD_RESET;
                end else if (wr_here) begin
                    case (wr_gsel)
                        csg_pkg::GSEL_FIELD: field_word_reg[g] <= hwdata;
                        csg_pkg::GSEL_ON_POS: on_word_reg[g] <= hwdata;
                        csg_pkg::GSEL_OFF_POS: off_word_reg[g] <= hwdata;
                        default: ;
                    endcase
                end
            end

            always_ff @(posedge clk) begin
                if (reset) begin
                    auto_reg <= 1'b0;
                    single_reg <= 1'b0;
                    toggled_reg <= 1'b0;
                    gate_on_reg[g] <= 1'b0;
                    gate_out_reg[g] <= 1'b0;
                end else begin
                    auto_reg <= take_auto | (auto_reg & ~auto_end);
                    if (field_sync) begin
                        single_reg <= take_single;
                    end
                    // manual works regardless of the sequencer
                    toggled_reg <= (man_en[g] & (on_hit | off_hit))
                        | (toggled_reg & ~field_sync);
                    // leaving manual mode keeps the current state
                    gate_on_reg[g] <= on_next;
                    gate_out_reg[g] <= gate_pol[g] ? on_next : ~on_next;
                end
            end
        end
    endgenerate

    assign mech_gate = gate_out_reg;

    ////////////////////////////////////////////////////////////////////////
    // substrate bias
    logic [1:0] bias_arm_reg;
    logic [1:0] bias_on_reg;
    logic [1:0] bias_out_reg;
    wire readout_end = field_sync & seq_readout & rd_last;
    wire seq_start = go_expose | go_readout_only;

    genvar b;
    generate
        for (b = 0; b < 2; b++) begin : bias
            wire take = seq_start & trig_pend_reg[csg_pkg::TRIG_BIAS_LSB + b];
            wire start = bias_arm_reg[b] & (bias_mode[b] ? seq_readout
                : seq_expose);
            // hold bit keeps it on; clearing it later releases the bias
            wire on_next = start | (bias_on_reg[b]
                & (bias_arm_reg[b] | bias_hold_after_readout[b]));

            always_ff @(posedge clk) begin
                if (reset) begin
                    bias_arm_reg[b] <= 1'b0;
                    bias_on_reg[b] <= 1'b0;
                    bias_out_reg[b] <= 1'b0;
                end else begin
                    bias_arm_reg[b] <= take | (bias_arm_reg[b] & ~readout_end);
                    bias_on_reg[b] <= on_next;
                    bias_out_reg[b] <= bias_polarity[b] ? on_next
                        : ~on_next;
                end
            end
        end
    endgenerate

    assign substrate_bias_a = bias_out_reg[0];
    assign substrate_bias_b = bias_out_reg[1];

    ////////////////////////////////////////////////////////////////////////
    // read mux
    wire [31:0] status_word = ({28'h0, gate_on_reg} << csg_pkg::STAT_GATE_LSB)
        | ({30'h0, bias_on_reg} << csg_pkg::STAT_BIAS_LSB)
        | ({30'h0, 2'(seq_reg)} << csg_pkg::STAT_SEQ_LSB)
        | ({29'h0, rd_field_reg} << csg_pkg::STAT_RDF_LSB)
        | ({20'h0, exp_field_reg} << csg_pkg::STAT_EXPF_LSB);
    wire rd_gate_region = rd_addr[7:6] == csg_pkg::GATE_REGION;
    wire [1:0] rd_gate = rd_addr[5:4];

    always_comb begin
        rd_value = 32'h0000_0000;
        if (rd_gate_region) begin
            case (rd_addr[3:2])
                csg_pkg::GSEL_FIELD: rd_value = field_word_reg[rd_gate];
                csg_pkg::GSEL_ON_POS: rd_value = on_word_reg[rd_gate];
                csg_pkg::GSEL_OFF_POS: rd_value = off_word_reg[rd_gate];
                default: rd_value = 32'h0000_0000;
            endcase
        end else begin
            case (rd_addr)
                csg_pkg::OFF_TRIGGER: rd_value = {24'h0, trig_pend_reg};
                csg_pkg::OFF_EXPNUM: rd_value = {20'h0, expnum_reg};
                csg_pkg::OFF_RDNUM: rd_value = {29'h0, rdnum_reg};
                csg_pkg::OFF_CTRL: rd_value = {14'h0, ctrl_reg};
                csg_pkg::OFF_STATUS: rd_value = status_word;
                default: rd_value = 32'h0000_0000;
            endcase
        end
    end

endmodule // csg_shutter_gen

//--- csg_video_model.sv
// free-running field and line timing, as the sensor side sees it
module csg_video_model #(
    parameter int PPL = 16,
    parameter int NL = 8
) (
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // one-cycle timing pulses
    output logic field_sync,
    output logic line_sync
);
    timeunit 1ns;
    timeprecision 1ps;
    int cnt;
    always_ff @(posedge clk) begin
        if (reset) begin
            cnt <= 0;
            field_sync <= 1'b0;
            line_sync <= 1'b0;
        end else begin
            cnt <= (cnt == PPL * NL - 1) ? 0 : cnt + 1;
            field_sync <= (cnt == PPL * NL - 1);
            // no line pulse on top of the field pulse
            line_sync <= (cnt % PPL == PPL - 1) && (cnt != PPL * NL - 1);
        end
    end
endmodule // csg_video_model

//--- csg_shutter_gen_props.sv
module csg_props (
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // register bus
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic [31:0] hrdata,
    input wire logic hresp,
    // timing and outputs
    input wire logic field_sync,
    input wire logic [3:0] mech_gate,
    input wire logic substrate_bias_a,
    input wire logic substrate_bias_b
);
    default clocking cb @(posedge clk); endclocking
    logic [7:0] wr_sr;
    logic [7:0] fs_sr;
    wire logic rd_take = hsel && htrans[1] && !hwrite && hready;
    wire logic wr_take = hsel && htrans[1] && hwrite && hready;
    // bias may only move shortly after a field start or a register write
    wire logic recent = (|wr_sr) || (|fs_sr);
    always_ff @(posedge clk) begin
        if (reset) begin
            wr_sr <= 8'h00;
            fs_sr <= 8'h00;
        end else begin
            wr_sr <= {wr_sr[6:0], wr_take};
            fs_sr <= {fs_sr[6:0], field_sync};
        end
    end
    ////////////////////////////////////////////////////////////////////
    a_reset_idle: assert property (reset |=> mech_gate == 4'h0 &&
        !substrate_bias_a && !substrate_bias_b) else $error("outputs active");
    a_reset_rdata: assert property (reset |=> hrdata == 32'h0)
        else $error("read data not cleared by reset");
    a_ready_high: assert property (disable iff (reset) hreadyout)
        else $error("wait state inserted");
    a_resp_okay: assert property (disable iff (reset) !hresp)
        else $error("error response");
    a_rdata_holds: assert property (disable iff (reset)
        !$past(rd_take) |-> $stable(hrdata)) else $error("hrdata moved");
    a_unmapped_zero: assert property (disable iff (reset)
        rd_take && haddr[7:0] == 8'h3c |=> hrdata == 32'h0)
        else $error("unmapped read not zero");
    a_bias_a_timed: assert property (disable iff (reset)
        $changed(substrate_bias_a) |-> recent) else $error("bias a mistimed");
    a_bias_b_timed: assert property (disable iff (reset)
        $changed(substrate_bias_b) |-> recent) else $error("bias b mistimed");
endmodule // csg_props

bind csg_shutter_gen csg_props u_props (.clk(clk), .reset(reset),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hready(hready), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
    .field_sync(field_sync), .mech_gate(mech_gate),
    .substrate_bias_a(substrate_bias_a), .substrate_bias_b(substrate_bias_b));

//--- test_csg_shutter_gen.sv
module test_csg_shutter_gen;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int PPL = 16;
    localparam int FP = PPL * 8;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic hreadyout, hresp, field_sync, line_sync, bias_a, bias_b;
    logic [31:0] hrdata;
    logic [3:0] mech_gate;
    int fails = 0;
    int check_count = 0;
    always #5 clk = ~clk;

    csg_video_model #(.PPL(PPL), .NL(8)) model_u (.clk(clk), .reset(reset),
        .field_sync(field_sync), .line_sync(line_sync));
    csg_shutter_gen dut_u (.clk(clk), .reset(reset), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
        .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
        .hrdata(hrdata), .hresp(hresp), .field_sync(field_sync),
        .line_sync(line_sync), .mech_gate(mech_gate),
        .substrate_bias_a(bias_a), .substrate_bias_b(bias_b));
    ////////////////////////////////////////////////////////////////////
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic chk_w(input string n, input logic [31:0] e,
                         input logic [31:0] g);
        check_count++;
        if (g !== e) begin
            fails++;
            $display("unexpected %s: expected %h seen %h", n, e, g);
        end
    endtask
    task automatic chk_b(input string n, input logic e, input logic g);
        chk_w(n, {31'h0, e}, {31'h0, g});
    endtask
    task automatic wait_rdy();
        int n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (hreadyout !== 1'b1 && n < 50);
        if (n >= 50) begin
            fails++;
            give_verdict();
        end
    endtask
    // one idle cycle ahead of each transfer keeps read-back after write safe
    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] r);
        @(posedge clk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {24'h0, a};
        hwrite <= w;
        wait_rdy();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        wait_rdy();
        r = hrdata;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        bus(1'b1, a, d, r);
    endtask
    task automatic rdc(input string n, input logic [7:0] a,
                       input logic [31:0] e);
        logic [31:0] r;
        bus(1'b0, a, 32'h0, r);
        chk_w(n, e, r);
    endtask
    // wait for the next field start, then n more cycles
    task automatic at(input int n);
        int k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (field_sync !== 1'b1 && k < 2 * FP);
        if (k >= 2 * FP) begin
            fails++;
            give_verdict();
        end
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic later(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    ////////////////////////////////////////////////////////////////////
    initial begin
        repeat (5) @(posedge clk);
        reset <= 1'b0;
        #1;
        chk_w("gates", 32'h0, {28'h0, mech_gate});
        chk_b("bias_b", 1'b0, bias_b);
        chk_b("bias_a", 1'b0, bias_a);
        chk_b("hresp", 1'b0, hresp);
        rdc("ctrl", 8'h0c, 32'h0000_300f);
        rdc("expnum", 8'h04, 32'h0);
        rdc("rdnum", 8'h08, 32'h0);
        rdc("status", 8'h10, 32'h0);
        rdc("g1_field", 8'h50, 32'h0);
        wr(8'h3c, 32'hffff_ffff);
        rdc("unmapped", 8'h3c, 32'h0);
        // automatic: gate 1 on in field 0, off in last exposure field
        at(8);
        wr(8'h50, 32'h0003_0000);
        wr(8'h54, 32'h0002_0003);
        wr(8'h58, 32'h0003_0004);
        wr(8'h04, 32'h0000_0003);
        wr(8'h0c, 32'h0002_b00f);
        wr(8'h00, 32'h0000_0072);
        rdc("trigger", 8'h00, 32'h72);
        for (int f = 0; f < 6; f++) begin
            at(FP - 8);
            chk_b("gate1", f < 3, mech_gate[1]);
            chk_b("bias_a", f < 5, bias_a);
            chk_b("bias_b", f > 3, bias_b);
        end
        wr(8'h0c, 32'h0000_b00f);
        later(8);
        chk_b("bias_b", 1'b0, bias_b);
        // single trigger: field words must be ignored
        at(8);
        wr(8'h60, 32'h0003_0003);
        wr(8'h64, 32'h0001_0002);
        wr(8'h68, 32'h0005_0000);
        wr(8'h00, 32'h0000_0004);
        at(3 * PPL);
        chk_b("gate2", 1'b1, mech_gate[2]);
        later(3 * PPL);
        chk_b("gate2", 1'b0, mech_gate[2]);
        at(FP - 8);
        chk_b("gate2", 1'b0, mech_gate[2]);
        rdc("trigger", 8'h00, 32'h0);
        // manual on, manual released, then a trigger only turns it off
        at(8);
        wr(8'h70, 32'h0007_0007);
        wr(8'h74, 32'h0002_0001);
        wr(8'h78, 32'h0004_0001);
        wr(8'h0c, 32'h0000_388f);
        at(3 * PPL);
        chk_b("gate3", 1'b1, mech_gate[3]);
        wr(8'h0c, 32'h0000_300f);
        at(FP - 8);
        chk_b("gate3", 1'b1, mech_gate[3]);
        wr(8'h00, 32'h0000_0008);
        at(3 * PPL);
        chk_b("gate3", 1'b1, mech_gate[3]);
        later(3 * PPL);
        chk_b("gate3", 1'b0, mech_gate[3]);
        // active-low gate 0 and bias a show their inactive level high
        wr(8'h0c, 32'h0000_200e);
        later(4);
        chk_w("gates", 32'h1, {28'h0, mech_gate});
        chk_b("bias_a", 1'b1, bias_a);
        chk_b("bias_b", 1'b0, bias_b);
        give_verdict();
    end
endmodule // test_csg_shutter_gen
